// ==== src/pcs_map.svh ====
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// apb byte offsets
`define PCS_OFS_OE_MASK0   8'h00
`define PCS_OFS_OE_MASK1   8'h04
`define PCS_OFS_OE_MASK2   8'h08
`define PCS_OFS_STEP_MASK  8'h0c
`define PCS_OFS_STEP_SIZE  8'h10
`define PCS_OFS_LIVE       8'h14
`define PCS_OFS_IRQ_STAT   8'h18
`define PCS_OFS_IRQ_MASK   8'h1c
`define PCS_OFS_FREQ_A     8'h20
`define PCS_OFS_FREQ_C     8'h24
`define PCS_OFS_FREQ_D     8'h28

// widths and counts
`define PCS_ADDR_W         8
`define PCS_N_OUT          7
`define PCS_N_LOOP         3
`define PCS_STEP_W         24

// reset values
`define PCS_RST_STEP_MASK  3'h0
`define PCS_RST_STEP_SIZE  24'h000001
`define PCS_RST_IRQ_MASK   8'h00

// live status field positions
`define PCS_LIVE_LOCK_LSB  0
`define PCS_LIVE_LOS_LSB   3
`define PCS_LIVE_OE_LSB    6

// interrupt status field positions
`define PCS_IRQ_UNLOCK_LSB 0
`define PCS_IRQ_LOS_LSB    3
`define PCS_IRQ_UP_BIT     6
`define PCS_IRQ_DOWN_BIT   7
`define PCS_IRQ_W          8

`endif

// ==== src/pcs_pkg.sv ====
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_STEP_NONE = 2'b00,
    PCS_STEP_UP   = 2'b01,
    PCS_STEP_DOWN = 2'b10
  } pcs_step_e;

  // status pins, all active low, index 0/1/2 = loop a/c/d or input 0/1/2
  typedef struct packed {
    logic [2:0] unlocked_n;
    logic [2:0] missing_n;
  } pcs_flags_s;

  // apb answer kept together
  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } pcs_apb_rsp_s;

endpackage

// ==== src/pcs_top.sv ====
`timescale 1ns/1ps
`include "pcs_map.svh"
module pcs_top #(
  parameter int N_OUT  = `PCS_N_OUT,
  parameter int STEP_W = `PCS_STEP_W
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [`PCS_ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  input  wire logic                  OUT_ENABLE_PIN_FIRST_N_I,
  input  wire logic                  OUT_ENABLE_PIN_SECOND_N_I,
  input  wire logic                  OUT_ENABLE_PIN_THIRD_N_I,
  input  wire logic [2:0]            LOOP_LOCKED_I,
  input  wire logic [2:0]            INPUT_LOS_I,
  input  wire logic                  FREQ_STEP_DOWN_PIN_I,
  input  wire logic                  FREQ_STEP_UP_PIN_I,
  output logic      [N_OUT-1:0]      CLK_OUT_EN_O,
  output logic                       UNLOCKED_FLAG_LOOP_A_N_O,
  output logic                       UNLOCKED_FLAG_LOOP_C_N_O,
  output logic                       UNLOCKED_FLAG_LOOP_D_N_O,
  output logic                       INPUT_MISSING_FLAG_0_N_O,
  output logic                       INPUT_MISSING_FLAG_1_N_O,
  output logic                       INPUT_MISSING_FLAG_2_N_O,
  output logic      [2:0]            FREQ_STEP_UP_O,
  output logic      [2:0]            FREQ_STEP_DOWN_O,
  output logic                       IRQ_O
);

  localparam int NL = `PCS_N_LOOP;
  localparam int IW = `PCS_IRQ_W;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // ---------------- apb slave ----------------
  pcs_pkg::pcs_apb_rsp_s apb_reg;
  pcs_pkg::pcs_apb_rsp_s apb_next;
  logic                  access;
  logic                  wr_done;
  logic                  hit;
  logic [31:0]           rd_data;

  logic [N_OUT-1:0]      oe_mask0_reg;
  logic [N_OUT-1:0]      oe_mask0_next;
  logic [N_OUT-1:0]      oe_mask1_reg;
  logic [N_OUT-1:0]      oe_mask1_next;
  logic [N_OUT-1:0]      oe_mask2_reg;
  logic [N_OUT-1:0]      oe_mask2_next;
  logic [NL-1:0]         step_mask_reg;
  logic [NL-1:0]         step_mask_next;
  logic [STEP_W-1:0]     step_size_reg;
  logic [STEP_W-1:0]     step_size_next;
  logic [IW-1:0]         irq_stat_reg;
  logic [IW-1:0]         irq_stat_next;
  logic [IW-1:0]         irq_mask_reg;
  logic [IW-1:0]         irq_mask_next;
  logic [31:0]           ofs_reg [NL];
  logic [31:0]           ofs_next [NL];

  // one wait state so the answer can come from flops
  always_comb begin
    access   = PSEL_I & PENABLE_I;
    wr_done  = access & apb_reg.ready & PWRITE_I;
    hit      = 1'b1;
    rd_data  = 32'h00000000;
    case (PADDR_I)
      `PCS_OFS_OE_MASK0:  rd_data = 32'(oe_mask0_reg);
      `PCS_OFS_OE_MASK1:  rd_data = 32'(oe_mask1_reg);
      `PCS_OFS_OE_MASK2:  rd_data = 32'(oe_mask2_reg);
      `PCS_OFS_STEP_MASK: rd_data = 32'(step_mask_reg);
      `PCS_OFS_STEP_SIZE: rd_data = 32'(step_size_reg);
      `PCS_OFS_LIVE: begin
        rd_data[`PCS_LIVE_LOCK_LSB +: 3] = LOOP_LOCKED_I;
        rd_data[`PCS_LIVE_LOS_LSB +: 3]  = INPUT_LOS_I;
        rd_data[`PCS_LIVE_OE_LSB +: 3]   = {OUT_ENABLE_PIN_THIRD_N_I,
                                            OUT_ENABLE_PIN_SECOND_N_I,
                                            OUT_ENABLE_PIN_FIRST_N_I};
      end
      `PCS_OFS_IRQ_STAT:  rd_data = 32'(irq_stat_reg);
      `PCS_OFS_IRQ_MASK:  rd_data = 32'(irq_mask_reg);
      `PCS_OFS_FREQ_A:    rd_data = ofs_reg[0];
      `PCS_OFS_FREQ_C:    rd_data = ofs_reg[1];
      `PCS_OFS_FREQ_D:    rd_data = ofs_reg[2];
      default:            hit = 1'b0;
    endcase
    apb_next       = apb_reg;
    apb_next.ready = access & ~apb_reg.ready;
    if (access & ~apb_reg.ready) begin
      apb_next.rdata  = PWRITE_I ? 32'h00000000 : rd_data;
      apb_next.slverr = ~hit;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      apb_reg <= '0;
    end else begin
      apb_reg <= apb_next;
    end
  end

  assign PRDATA_O  = apb_reg.rdata;
  assign PREADY_O  = apb_reg.ready;
  assign PSLVERR_O = apb_reg.slverr;

  // ---------------- configuration registers ----------------
  always_comb begin
    oe_mask0_next  = oe_mask0_reg;
    oe_mask1_next  = oe_mask1_reg;
    oe_mask2_next  = oe_mask2_reg;
    step_mask_next = step_mask_reg;
    step_size_next = step_size_reg;
    irq_mask_next  = irq_mask_reg;
    if (wr_done) begin
      case (PADDR_I)
        `PCS_OFS_OE_MASK0:  oe_mask0_next  = PWDATA_I[N_OUT-1:0];
        `PCS_OFS_OE_MASK1:  oe_mask1_next  = PWDATA_I[N_OUT-1:0];
        `PCS_OFS_OE_MASK2:  oe_mask2_next  = PWDATA_I[N_OUT-1:0];
        `PCS_OFS_STEP_MASK: step_mask_next = PWDATA_I[NL-1:0];
        `PCS_OFS_STEP_SIZE: step_size_next = PWDATA_I[STEP_W-1:0];
        `PCS_OFS_IRQ_MASK:  irq_mask_next  = PWDATA_I[IW-1:0];
        default:            ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      oe_mask0_reg  <= {N_OUT{1'b1}};
      oe_mask1_reg  <= '0;
      oe_mask2_reg  <= '0;
      step_mask_reg <= `PCS_RST_STEP_MASK;
      step_size_reg <= STEP_W'(`PCS_RST_STEP_SIZE);
      irq_mask_reg  <= `PCS_RST_IRQ_MASK;
    end else begin
      oe_mask0_reg  <= oe_mask0_next;
      oe_mask1_reg  <= oe_mask1_next;
      oe_mask2_reg  <= oe_mask2_next;
      step_mask_reg <= step_mask_next;
      step_size_reg <= step_size_next;
      irq_mask_reg  <= irq_mask_next;
    end
  end

  // ---------------- output enables ----------------
  logic [N_OUT-1:0] clk_en_reg;
  logic [N_OUT-1:0] clk_en_next;

  // an output no mask claims stays enabled
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      clk_en_next[i] = ~((oe_mask0_reg[i] & OUT_ENABLE_PIN_FIRST_N_I) |
                         (oe_mask1_reg[i] & OUT_ENABLE_PIN_SECOND_N_I) |
                         (oe_mask2_reg[i] & OUT_ENABLE_PIN_THIRD_N_I));
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_en_reg <= '0;
    end else begin
      clk_en_reg <= clk_en_next;
    end
  end

  assign CLK_OUT_EN_O = clk_en_reg;

  // ---------------- status pins ----------------
  pcs_pkg::pcs_flags_s flags_reg;
  pcs_pkg::pcs_flags_s flags_next;

  always_comb begin
    flags_next.unlocked_n = LOOP_LOCKED_I;
    flags_next.missing_n  = ~INPUT_LOS_I;
  end

  // reset shows unlocked and missing until the first real sample
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign UNLOCKED_FLAG_LOOP_A_N_O = flags_reg.unlocked_n[0];
  assign UNLOCKED_FLAG_LOOP_C_N_O = flags_reg.unlocked_n[1];
  assign UNLOCKED_FLAG_LOOP_D_N_O = flags_reg.unlocked_n[2];
  assign INPUT_MISSING_FLAG_0_N_O = flags_reg.missing_n[0];
  assign INPUT_MISSING_FLAG_1_N_O = flags_reg.missing_n[1];
  assign INPUT_MISSING_FLAG_2_N_O = flags_reg.missing_n[2];

  // ---------------- frequency stepping ----------------
  logic              up_prev_reg;
  logic              dn_prev_reg;
  logic [2:0]        up_pls_reg;
  logic [2:0]        up_pls_next;
  logic [2:0]        dn_pls_reg;
  logic [2:0]        dn_pls_next;
  logic [31:0]       step_ext;
  pcs_pkg::pcs_step_e step_cmd;

  assign step_ext = 32'(step_size_reg);

  // both pins rising together cancel: no step either way
  always_comb begin
    case ({rise(FREQ_STEP_DOWN_PIN_I, dn_prev_reg),
           rise(FREQ_STEP_UP_PIN_I, up_prev_reg)})
      2'b01:   step_cmd = pcs_pkg::PCS_STEP_UP;
      2'b10:   step_cmd = pcs_pkg::PCS_STEP_DOWN;
      default: step_cmd = pcs_pkg::PCS_STEP_NONE;
    endcase
    for (int k = 0; k < NL; k++) begin
      ofs_next[k]    = ofs_reg[k];
      up_pls_next[k] = 1'b0;
      dn_pls_next[k] = 1'b0;
      if (!step_mask_reg[k]) begin
        case (step_cmd)
          pcs_pkg::PCS_STEP_UP: begin
            ofs_next[k]    = ofs_reg[k] + step_ext;
            up_pls_next[k] = 1'b1;
          end
          pcs_pkg::PCS_STEP_DOWN: begin
            ofs_next[k]    = ofs_reg[k] - step_ext;
            dn_pls_next[k] = 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  // prev flops start high so a pin held high at reset is no step
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      up_prev_reg <= 1'b1;
      dn_prev_reg <= 1'b1;
      up_pls_reg  <= '0;
      dn_pls_reg  <= '0;
      for (int k = 0; k < NL; k++) begin
        ofs_reg[k] <= 32'h00000000;
      end
    end else begin
      up_prev_reg <= FREQ_STEP_UP_PIN_I;
      dn_prev_reg <= FREQ_STEP_DOWN_PIN_I;
      up_pls_reg  <= up_pls_next;
      dn_pls_reg  <= dn_pls_next;
      for (int k = 0; k < NL; k++) begin
        ofs_reg[k] <= ofs_next[k];
      end
    end
  end

  assign FREQ_STEP_UP_O   = up_pls_reg;
  assign FREQ_STEP_DOWN_O = dn_pls_reg;

  // ---------------- interrupts ----------------
  logic [IW-1:0] events;
  logic [IW-1:0] w1c;
  logic          irq_reg;
  logic          irq_next;

  // set wins over a clear in the same cycle
  always_comb begin
    events = '0;
    events[`PCS_IRQ_UNLOCK_LSB +: 3] = flags_reg.unlocked_n & ~LOOP_LOCKED_I;
    events[`PCS_IRQ_LOS_LSB +: 3]    = flags_reg.missing_n & INPUT_LOS_I;
    events[`PCS_IRQ_UP_BIT]          = |up_pls_next;
    events[`PCS_IRQ_DOWN_BIT]        = |dn_pls_next;
    w1c = (wr_done && PADDR_I == `PCS_OFS_IRQ_STAT) ? PWDATA_I[IW-1:0] : '0;
    irq_stat_next = (irq_stat_reg & ~w1c) | events;
    // built from next values so the pin has no extra cycle of lag
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_reg      <= irq_next;
    end
  end

  assign IRQ_O = irq_reg;

  // ---------------- assertions ----------------
  AST_OE_PIN_MASKED: assert property (@(posedge CLK_I) disable iff (RST_I)
    OUT_ENABLE_PIN_SECOND_N_I && oe_mask1_reg[0] |=> !CLK_OUT_EN_O[0])
    else $error("masked output not disabled by second pin");

  AST_OE_UNMASKED: assert property (@(posedge CLK_I) disable iff (RST_I)
    !oe_mask0_reg[1] && !oe_mask1_reg[1] && !oe_mask2_reg[1]
      |=> CLK_OUT_EN_O[1])
    else $error("unclaimed output was disabled");

  AST_OE_DEFAULT: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RST_I && &oe_mask0_reg && oe_mask1_reg == '0 && oe_mask2_reg == '0
      |-> ##1 (CLK_OUT_EN_O == {N_OUT{!$past(OUT_ENABLE_PIN_FIRST_N_I)}}))
    else $error("default mapping not governed by first pin");

  AST_UNLOCK_LOW: assert property (@(posedge CLK_I) disable iff (RST_I)
    !LOOP_LOCKED_I[0] |=> !UNLOCKED_FLAG_LOOP_A_N_O)
    else $error("loop a unlocked but flag high");

  AST_LOCK_HIGH: assert property (@(posedge CLK_I) disable iff (RST_I)
    LOOP_LOCKED_I[2] |=> UNLOCKED_FLAG_LOOP_D_N_O)
    else $error("loop d locked but flag low");

  AST_LOS_FOLLOW: assert property (@(posedge CLK_I) disable iff (RST_I)
    !RST_I |=> INPUT_MISSING_FLAG_1_N_O == !$past(INPUT_LOS_I[1]))
    else $error("input 1 missing flag does not follow status");

  AST_STEP_DOWN: assert property (@(posedge CLK_I) disable iff (RST_I)
    FREQ_STEP_DOWN_PIN_I && !dn_prev_reg && !(FREQ_STEP_UP_PIN_I && !up_prev_reg)
      && !step_mask_reg[0]
      |=> FREQ_STEP_DOWN_O[0]
          && ofs_reg[0] == $past(ofs_reg[0]) - $past(step_ext))
    else $error("decrement did not lower loop a by one step");

  AST_STEP_UP: assert property (@(posedge CLK_I) disable iff (RST_I)
    FREQ_STEP_UP_PIN_I && !up_prev_reg && !(FREQ_STEP_DOWN_PIN_I && !dn_prev_reg)
      && !step_mask_reg[1]
      |=> FREQ_STEP_UP_O[1]
          && ofs_reg[1] == $past(ofs_reg[1]) + $past(step_ext))
    else $error("increment did not raise loop c by one step");

  AST_STEP_MASKED: assert property (@(posedge CLK_I) disable iff (RST_I)
    step_mask_reg[2] |=> !FREQ_STEP_UP_O[2] && !FREQ_STEP_DOWN_O[2]
                         && $stable(ofs_reg[2]))
    else $error("masked loop d changed frequency");

  AST_APB_WAIT: assert property (@(posedge CLK_I) disable iff (RST_I)
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("apb answer later than one wait state");

  AST_IRQ_LEVEL: assert property (@(posedge CLK_I) disable iff (RST_I)
    IRQ_O == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt level differs from unmasked status");

endmodule

// ==== tb/pcs_board.sv ====
`timescale 1ns/1ps
// board-side controller: drives the pins of the block like real glue logic
module pcs_board (
  input  wire logic       clk_i,
  output logic      [2:0] oe_n_o,
  output logic      [2:0] locked_o,
  output logic      [2:0] los_o,
  output logic            down_o,
  output logic            up_o
);
  // pins start at their pulled levels: enables low, step pins low
  initial begin
    oe_n_o   = 3'h0;
    locked_o = 3'h0;
    los_o    = 3'h0;
    down_o   = 1'b0;
    up_o     = 1'b0;
  end

  task automatic set_levels(input logic [2:0] oe_n, lk, ls);
    @(posedge clk_i);
    oe_n_o   <= oe_n;
    locked_o <= lk;
    los_o    <= ls;
  endtask

  // held two cycles so the edge detector sees a clean low-high-low
  task automatic step(input logic up);
    @(posedge clk_i);
    if (up) begin
      up_o <= 1'b1;
    end else begin
      down_o <= 1'b1;
    end
    repeat (2) @(posedge clk_i);
    up_o   <= 1'b0;
    down_o <= 1'b0;
  endtask
endmodule

// ==== tb/test_pin_control_status_logic.sv ====
`timescale 1ns/1ps
module test_pin_control_status_logic;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  oe_n, locked, los, up_o, dn_o, up_seen, dn_seen;
  logic        down_pin, up_pin, irq, fa, fc, fd, m0, m1, m2;
  logic [6:0]  en;
  int          err_total = 0;
  int          compares = 0;

  always #2.5 clk = ~clk;

  pcs_top i_pcs_top (
    .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .OUT_ENABLE_PIN_FIRST_N_I(oe_n[0]), .OUT_ENABLE_PIN_SECOND_N_I(oe_n[1]),
    .OUT_ENABLE_PIN_THIRD_N_I(oe_n[2]), .LOOP_LOCKED_I(locked),
    .INPUT_LOS_I(los), .FREQ_STEP_DOWN_PIN_I(down_pin),
    .FREQ_STEP_UP_PIN_I(up_pin), .CLK_OUT_EN_O(en),
    .UNLOCKED_FLAG_LOOP_A_N_O(fa), .UNLOCKED_FLAG_LOOP_C_N_O(fc),
    .UNLOCKED_FLAG_LOOP_D_N_O(fd), .INPUT_MISSING_FLAG_0_N_O(m0),
    .INPUT_MISSING_FLAG_1_N_O(m1), .INPUT_MISSING_FLAG_2_N_O(m2),
    .FREQ_STEP_UP_O(up_o), .FREQ_STEP_DOWN_O(dn_o), .IRQ_O(irq));

  pcs_board i_pcs_board (
    .clk_i(clk), .oe_n_o(oe_n), .locked_o(locked), .los_o(los),
    .down_o(down_pin), .up_o(up_pin));

  // step pulses last one cycle, so keep the last non-zero pattern
  always @(posedge clk) begin
    if (up_o != 3'h0) up_seen <= up_o;
    if (dn_o != 3'h0) dn_seen <= dn_o;
  end

  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset_map();
    rchk(8'h00, 32'h7f);
    i_pcs_board.set_levels(3'b000, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h7f);
    i_pcs_board.set_levels(3'b110, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h7f);
    i_pcs_board.set_levels(3'b001, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h00);
  endtask

  task automatic t_masks();
    wreg(8'h00, 32'h70);
    wreg(8'h04, 32'h05);
    wreg(8'h08, 32'h0a);
    rchk(8'h04, 32'h05);
    i_pcs_board.set_levels(3'b010, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h7a);
    i_pcs_board.set_levels(3'b100, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h75);
    i_pcs_board.set_levels(3'b001, 3'h0, 3'h0);
    settle();
    chk({25'h0, en}, 32'h0f);
  endtask

  task automatic t_flags();
    i_pcs_board.set_levels(3'b000, 3'b101, 3'b010);
    settle();
    chk({29'h0, fd, fc, fa}, 32'h5);
    chk({29'h0, m2, m1, m0}, 32'h5);
    i_pcs_board.set_levels(3'b000, 3'b010, 3'b101);
    settle();
    chk({29'h0, fd, fc, fa}, 32'h2);
    chk({29'h0, m2, m1, m0}, 32'h2);
    rchk(8'h14, 32'h2a);
    // lock lost on a and d, signal lost on 1 then on 0 and 2
    rchk(8'h18, 32'h3d);
  endtask

  task automatic t_steps();
    wreg(8'h18, 32'hff);
    wreg(8'h10, 32'h5);
    wreg(8'h0c, 32'h2);
    wreg(8'h1c, 32'hc0);
    i_pcs_board.step(1'b1);
    settle();
    chk({29'h0, up_seen}, 32'h5);
    rchk(8'h20, 32'h5);
    rchk(8'h24, 32'h0);
    rchk(8'h28, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wreg(8'h18, 32'h40);
    settle();
    chk({31'h0, irq}, 32'h0);
    i_pcs_board.step(1'b0);
    settle();
    chk({29'h0, dn_seen}, 32'h5);
    rchk(8'h20, 32'h0);
    wreg(8'h0c, 32'h5);
    i_pcs_board.step(1'b1);
    settle();
    chk({29'h0, up_seen}, 32'h2);
    rchk(8'h24, 32'h5);
  endtask

  // a hole in the map must answer with an error and zero data
  task automatic t_unmapped();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 8'h30, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic print_verdict();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset_map();
    t_masks();
    t_flags();
    t_steps();
    t_unmapped();
    print_verdict();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule
